// [src/sra_top.sv]
/*
 * Soft reset distribution, reset pulse shaping and AGC gain preload.
 * Assumes one clock; front-end and back-end rates are one-cycle enables,
 * and the register port is a plain strobe port with read data one cycle later.
 */
`timescale 1ns/1ps

// What this block does
// - Soft reset clears coordinate converter iteration counter, aborting its work.
// - Soft reset clears output FIFO control decoder and write address.
// - Soft reset drops FIFO data-available indication and the interrupt output.
// - Soft reset clears FIFO depth and full flags, sets empty flag.
// - Soft reset puts FIFO read pointer at seven, write pointer at zero.
// - Soft reset zeroes snapshot group, loads interval, clears snapshot addresses.
// - Soft reset reloads serial shift, word, sync and divider counters.
// - Front-end reset lasts exactly ten front-end clock periods.
// - Back-end reset lasts exactly ten back-end clock periods.
// - Writing gain preload word strobes bits 15:5 into accumulator top bits.
// - Bits 15:12 give gain exponent, bits 11:5 mantissa, low bits ignored.
// - Mantissa weight is binary 01 followed by the seven fraction bits.
// - Accumulator input takes limiter output, or preload value during load strobe.
// - Gain preload is applied on the back-end rate.
// - Unless clear inhibit is set, reset word or second sync clears accumulator.
// - Config bit 22 lets first sync also start the back-end reset.
module sra_top
   import sra_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Rate enables for the two processing domains.
   input  wire logic        front_end_clock,
   input  wire logic        back_end_clock,
   // Register port.
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   // Sync inputs.
   input  wire logic        first_sync_input,
   input  wire logic        second_sync_input,
   // Activity of the controlled datapath blocks.
   input  wire logic        cordic_start,
   input  wire logic        fifo_push,
   input  wire logic        fifo_pop,
   input  wire logic        snap_tick,
   input  wire logic        serial_tick,
   input  wire logic [15:0] limiter_out,
   // Reset and control outputs.
   output logic             fe_reset,
   output logic             be_reset,
   output logic             cordic_busy,
   output logic      [3:0]  cordic_iter,
   output sra_fifo_t        fifo_state,
   output sra_snap_t        snap_state,
   output sra_serial_t      serial_state,
   // AGC outputs.
   output logic             agc_load_strobe,
   output logic      [3:0]  agc_exponent,
   output logic      [8:0]  agc_mantissa,
   output logic      [15:0] agc_accumulator,
   // Interrupt.
   output logic             host_interrupt
);
   import sra_pkg::*;

   // ==========================================
   // State
   // ==========================================
   typedef struct packed {
      logic [31:0]             rdata;
      logic [31:0]             config_word;
      logic [SRA_IRQ_BITS-1:0] irq_status;
      logic [SRA_IRQ_BITS-1:0] irq_mask;
      logic                    fe_pend;
      logic                    be_pend;
      logic [3:0]              fe_cnt;
      logic [3:0]              be_cnt;
      logic                    fe_reset;
      logic                    be_reset;
      logic                    clr_pend;
      logic                    load_pend;
      logic [10:0]             load_val;
      logic                    load_strobe;
      logic [15:0]             acc;
      logic                    cordic_busy;
      logic [3:0]              cordic_iter;
      sra_fifo_t               fifo;
      sra_snap_t               snap;
      sra_serial_t             ser;
   } sra_state_t;

   sra_state_t state;
   sra_state_t next_state;
   logic [1:0] rst_sync;
   logic       rst_n;

   // ==========================================
   // Reset release
   // ==========================================
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // ==========================================
   // Next state
   // ==========================================
   always_comb begin
      logic soft_wr;
      logic gain_wr;
      logic fe_start;
      logic be_start;
      logic fifo_in;
      logic fifo_out;
      soft_wr  = wr && (addr == SRA_ADDR_SOFT_RESET);
      gain_wr  = wr && (addr == SRA_ADDR_GAIN_LOAD);
      fe_start = 1'b0;
      be_start = 1'b0;
      fifo_in  = 1'b0;
      fifo_out = 1'b0;
      next_state = state;

      // Register reads answer in the following cycle only.
      next_state.rdata = 32'h0000_0000;
      if (rd) begin
         unique case (addr)
            SRA_ADDR_CONFIG:     next_state.rdata = state.config_word;
            SRA_ADDR_IRQ_STATUS: next_state.rdata = {28'h000_0000, state.irq_status};
            SRA_ADDR_IRQ_MASK:   next_state.rdata = {28'h000_0000, state.irq_mask};
            SRA_ADDR_STATE:      next_state.rdata = {17'h0_0000, state.fifo};
            SRA_ADDR_AGC_ACC:    next_state.rdata = {16'h0000, state.acc};
            default:             next_state.rdata = 32'h0000_0000;
         endcase
      end
      if (wr && addr == SRA_ADDR_CONFIG) begin
         next_state.config_word = wdata;
      end
      if (wr && addr == SRA_ADDR_IRQ_MASK) begin
         next_state.irq_mask = wdata[SRA_IRQ_BITS-1:0];
      end
      if (wr && addr == SRA_ADDR_IRQ_STATUS) begin
         next_state.irq_status = state.irq_status & ~wdata[SRA_IRQ_BITS-1:0];
      end

      // Requests are held until each domain's own enable picks them up.
      if (soft_wr || first_sync_input) begin
         next_state.fe_pend = 1'b1;
      end
      if (soft_wr || (first_sync_input && state.config_word[SRA_CFG_SYNC1_BOTH])) begin
         next_state.be_pend = 1'b1;
      end
      if ((soft_wr || second_sync_input) && !state.config_word[SRA_CFG_CLEAR_INHIBIT]) begin
         next_state.clr_pend = 1'b1;
      end
      if (gain_wr) begin
         next_state.load_pend = 1'b1;
         next_state.load_val  = wdata[SRA_GAIN_EXP_HI:SRA_GAIN_MAN_LO];
      end

      // Front-end reset stretch.
      if (front_end_clock) begin
         if (state.fe_pend) begin
            fe_start = 1'b1;
            next_state.fe_pend  = 1'b0;
            next_state.fe_reset = 1'b1;
            next_state.fe_cnt   = SRA_RESET_PERIODS - 4'h1;
         end else if (state.fe_reset) begin
            if (state.fe_cnt == 4'h0) begin
               next_state.fe_reset = 1'b0;
               next_state.irq_status[SRA_IRQ_FE_DONE] = 1'b1;
            end else begin
               next_state.fe_cnt = state.fe_cnt - 4'h1;
            end
         end
      end

      // Back-end reset stretch and the back-end datapath control.
      next_state.load_strobe = 1'b0;
      if (back_end_clock) begin
         if (state.be_pend) begin
            be_start = 1'b1;
            next_state.be_pend  = 1'b0;
            next_state.be_reset = 1'b1;
            next_state.be_cnt   = SRA_RESET_PERIODS - 4'h1;
         end else if (state.be_reset) begin
            if (state.be_cnt == 4'h0) begin
               next_state.be_reset = 1'b0;
               next_state.irq_status[SRA_IRQ_BE_DONE] = 1'b1;
            end else begin
               next_state.be_cnt = state.be_cnt - 4'h1;
            end
         end

         // The loop register input chooses preload over limiter.
         if (state.load_pend) begin
            next_state.load_pend   = 1'b0;
            next_state.load_strobe = 1'b1;
            next_state.acc = {state.load_val, 5'h00};
            next_state.irq_status[SRA_IRQ_AGC_LOADED] = 1'b1;
         end else if (state.clr_pend) begin
            next_state.clr_pend = 1'b0;
            next_state.acc = 16'h0000;
         end else begin
            next_state.acc = limiter_out;
         end

         if (be_start || state.be_reset) begin
            next_state.cordic_busy = 1'b0;
            next_state.cordic_iter = 4'h0;
            next_state.fifo.decode_busy = 1'b0;
            next_state.fifo.wr_ptr = SRA_FIFO_WR_INIT;
            next_state.fifo.rd_ptr = SRA_FIFO_RD_INIT;
            next_state.fifo.data_avail = 1'b0;
            next_state.fifo.count = 4'h0;
            next_state.fifo.depth = 1'b0;
            next_state.fifo.full  = 1'b0;
            next_state.fifo.empty = 1'b1;
            next_state.irq_status[SRA_IRQ_FIFO_AVAIL] = 1'b0;
            next_state.snap.group_num = 3'h0;
            next_state.snap.interval  = SRA_SNAP_INTERVAL;
            next_state.snap.rd_addr   = 3'h0;
            next_state.snap.wr_addr   = 3'h0;
            next_state.ser.shift_cnt = SRA_SER_SHIFT;
            next_state.ser.word_cnt  = SRA_SER_WORDS;
            next_state.ser.sync_cnt  = SRA_SER_SYNC;
            next_state.ser.div_cnt   = SRA_SER_DIV;
         end else begin
            // Coordinate converter iterations.
            if (state.cordic_busy) begin
               next_state.cordic_iter = state.cordic_iter + 4'h1;
               if (state.cordic_iter == SRA_CORDIC_ITERS) begin
                  next_state.cordic_busy = 1'b0;
               end
            end else if (cordic_start) begin
               next_state.cordic_busy = 1'b1;
               next_state.cordic_iter = 4'h0;
            end
            // FIFO pointer and flag tracking.
            fifo_in  = fifo_push && !state.fifo.full;
            fifo_out = fifo_pop && !state.fifo.empty;
            next_state.fifo.decode_busy = fifo_in || fifo_out;
            if (fifo_in) begin
               next_state.fifo.wr_ptr = state.fifo.wr_ptr + 3'h1;
            end
            if (fifo_out) begin
               next_state.fifo.rd_ptr = state.fifo.rd_ptr + 3'h1;
            end
            if (fifo_in && !fifo_out) begin
               next_state.fifo.count = state.fifo.count + 4'h1;
            end else if (fifo_out && !fifo_in) begin
               next_state.fifo.count = state.fifo.count - 4'h1;
            end
            next_state.fifo.empty = (next_state.fifo.count == 4'h0);
            next_state.fifo.full  = (next_state.fifo.count == SRA_FIFO_FULL);
            next_state.fifo.depth = (next_state.fifo.count >= SRA_FIFO_DEPTH_MK);
            next_state.fifo.data_avail = !next_state.fifo.empty;
            if (fifo_in) begin
               next_state.irq_status[SRA_IRQ_FIFO_AVAIL] = 1'b1;
            end
            // Snapshot interval and group tracking.
            if (snap_tick) begin
               if (state.snap.interval == 8'h00) begin
                  next_state.snap.interval  = SRA_SNAP_INTERVAL;
                  next_state.snap.group_num = state.snap.group_num + 3'h1;
                  next_state.snap.wr_addr   = state.snap.wr_addr + 3'h1;
               end else begin
                  next_state.snap.interval = state.snap.interval - 8'h01;
               end
            end
            if (fifo_out) begin
               next_state.snap.rd_addr = state.snap.rd_addr + 3'h1;
            end
            // Serial output counters: divider, then bit, then word.
            if (serial_tick) begin
               if (state.ser.div_cnt == 4'h0) begin
                  next_state.ser.div_cnt = SRA_SER_DIV;
                  if (state.ser.shift_cnt == 4'h0) begin
                     next_state.ser.shift_cnt = SRA_SER_SHIFT;
                     next_state.ser.sync_cnt  = SRA_SER_SYNC;
                     if (state.ser.word_cnt == 3'h0) begin
                        next_state.ser.word_cnt = SRA_SER_WORDS;
                     end else begin
                        next_state.ser.word_cnt = state.ser.word_cnt - 3'h1;
                     end
                  end else begin
                     next_state.ser.shift_cnt = state.ser.shift_cnt - 4'h1;
                     if (state.ser.sync_cnt != 2'h0) begin
                        next_state.ser.sync_cnt = state.ser.sync_cnt - 2'h1;
                     end
                  end
               end else begin
                  next_state.ser.div_cnt = state.ser.div_cnt - 4'h1;
               end
            end
         end
      end
   end

   // ==========================================
   // Registers
   // ==========================================
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
         state.config_word <= SRA_CONFIG_RESET;
         state.fifo.rd_ptr <= SRA_FIFO_RD_INIT;
         state.fifo.empty  <= 1'b1;
         state.snap.interval <= SRA_SNAP_INTERVAL;
         state.ser.shift_cnt <= SRA_SER_SHIFT;
         state.ser.word_cnt  <= SRA_SER_WORDS;
         state.ser.sync_cnt  <= SRA_SER_SYNC;
         state.ser.div_cnt   <= SRA_SER_DIV;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================
   // Outputs
   // ==========================================
   assign rdata           = state.rdata;
   assign fe_reset        = state.fe_reset;
   assign be_reset        = state.be_reset;
   assign cordic_busy     = state.cordic_busy;
   assign cordic_iter     = state.cordic_iter;
   assign fifo_state      = state.fifo;
   assign snap_state      = state.snap;
   assign serial_state    = state.ser;
   assign agc_load_strobe = state.load_strobe;
   assign agc_accumulator = state.acc;
   assign agc_exponent    = state.acc[SRA_GAIN_EXP_HI:SRA_GAIN_EXP_LO];
   assign agc_mantissa    = {SRA_MANT_INT, state.acc[SRA_GAIN_MAN_HI:SRA_GAIN_MAN_LO]};
   // The interrupt stays low for the whole back-end reset.
   assign host_interrupt  = (|(state.irq_status & state.irq_mask)) && !state.be_reset;

endmodule

// [inc/sra_pkg.sv]
/*
 * Shared constants and types for the soft reset and AGC gain load block.
 * Assumes a single 100 MHz clock; the two processing rates arrive as enables.
 */
package sra_pkg;

   // ==========================================
   // Register indices on the plain register port
   // ==========================================
   localparam logic [7:0] SRA_ADDR_SOFT_RESET = 8'h19;
   localparam logic [7:0] SRA_ADDR_GAIN_LOAD  = 8'h1a;
   localparam logic [7:0] SRA_ADDR_CONFIG     = 8'h20;
   localparam logic [7:0] SRA_ADDR_IRQ_STATUS = 8'h21;
   localparam logic [7:0] SRA_ADDR_IRQ_MASK   = 8'h22;
   localparam logic [7:0] SRA_ADDR_STATE      = 8'h23;
   localparam logic [7:0] SRA_ADDR_AGC_ACC    = 8'h24;

   // ==========================================
   // Field positions
   // ==========================================
   localparam int SRA_CFG_CLEAR_INHIBIT = 15;
   localparam int SRA_CFG_SYNC1_BOTH    = 22;
   localparam int SRA_GAIN_EXP_HI       = 15;
   localparam int SRA_GAIN_EXP_LO       = 12;
   localparam int SRA_GAIN_MAN_HI       = 11;
   localparam int SRA_GAIN_MAN_LO       = 5;
   localparam int SRA_IRQ_BITS          = 4;
   localparam int SRA_IRQ_FIFO_AVAIL    = 0;
   localparam int SRA_IRQ_FE_DONE       = 1;
   localparam int SRA_IRQ_BE_DONE       = 2;
   localparam int SRA_IRQ_AGC_LOADED    = 3;

   // ==========================================
   // Reset values and counts
   // ==========================================
   localparam logic [3:0]  SRA_RESET_PERIODS  = 4'hA;
   localparam logic [2:0]  SRA_FIFO_RD_INIT   = 3'h7;
   localparam logic [2:0]  SRA_FIFO_WR_INIT   = 3'h0;
   localparam logic [3:0]  SRA_FIFO_FULL      = 4'h8;
   localparam logic [3:0]  SRA_FIFO_DEPTH_MK  = 4'h4;
   localparam logic [3:0]  SRA_CORDIC_ITERS   = 4'hF;
   localparam logic [7:0]  SRA_SNAP_INTERVAL  = 8'h3F;
   localparam logic [3:0]  SRA_SER_SHIFT      = 4'hF;
   localparam logic [2:0]  SRA_SER_WORDS      = 3'h3;
   localparam logic [1:0]  SRA_SER_SYNC       = 2'h1;
   localparam logic [3:0]  SRA_SER_DIV        = 4'h3;
   localparam logic [1:0]  SRA_MANT_INT       = 2'h1;
   localparam logic [31:0] SRA_CONFIG_RESET   = 32'h0000_0000;

   // ==========================================
   // Types
   // ==========================================
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } sra_bus_req_t;

   typedef struct packed {
      logic [2:0] rd_ptr;
      logic [2:0] wr_ptr;
      logic [3:0] count;
      logic       decode_busy;
      logic       empty;
      logic       full;
      logic       depth;
      logic       data_avail;
   } sra_fifo_t;

   typedef struct packed {
      logic [2:0] group_num;
      logic [7:0] interval;
      logic [2:0] rd_addr;
      logic [2:0] wr_addr;
   } sra_snap_t;

   typedef struct packed {
      logic [3:0] shift_cnt;
      logic [2:0] word_cnt;
      logic [1:0] sync_cnt;
      logic [3:0] div_cnt;
   } sra_serial_t;

endpackage

// [tb/sra_props.sv]
/*
 * Checker for sra_top, attached by bind.
 * Assumes one clock and the rate enables of the design's top ports.
 */
`timescale 1ns/1ps
module sra_props
   import sra_pkg::*;
(
   // Clock and reset.
   input wire logic                clk,
   input wire logic                reset_n,
   // Rate enables.
   input wire logic                front_end_clock,
   input wire logic                back_end_clock,
   // Register port inputs.
   input wire logic [7:0]          addr,
   input wire logic [31:0]         wdata,
   input wire logic                wr,
   // Watched outputs.
   input wire logic                fe_reset,
   input wire logic                be_reset,
   input wire logic                cordic_busy,
   input wire logic [3:0]          cordic_iter,
   input wire sra_pkg::sra_fifo_t   fifo_state,
   input wire sra_pkg::sra_snap_t   snap_state,
   input wire sra_pkg::sra_serial_t serial_state,
   input wire logic                agc_load_strobe,
   input wire logic [3:0]          agc_exponent,
   input wire logic [8:0]          agc_mantissa,
   input wire logic [15:0]         agc_accumulator,
   input wire logic                host_interrupt
);
   logic [3:0] fe_cnt;
   logic [3:0] be_cnt;
   logic       forced;
   logic [10:0] gain_seen;

   // Enables seen while each reset is high; the starting enable comes before the rise.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fe_cnt <= 4'h0;
         be_cnt <= 4'h0;
         gain_seen <= 11'h000;
      end else begin
         fe_cnt <= fe_reset ? fe_cnt + {3'h0, front_end_clock} : 4'h0;
         be_cnt <= be_reset ? be_cnt + {3'h0, back_end_clock} : 4'h0;
         if (wr && addr == SRA_ADDR_GAIN_LOAD) begin
            gain_seen <= wdata[SRA_GAIN_EXP_HI:SRA_GAIN_MAN_LO];
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_fe_ten_periods: assert property ($fell(fe_reset) |-> fe_cnt == SRA_RESET_PERIODS)
      else $error("front-end reset width wrong");
   a_be_ten_periods: assert property ($fell(be_reset) |-> be_cnt == SRA_RESET_PERIODS)
      else $error("back-end reset width wrong");
   a_fe_start_edge: assert property ($rose(fe_reset) |-> $past(front_end_clock))
      else $error("front-end reset rose off an enable");
   a_be_start_edge: assert property ($rose(be_reset) |-> $past(back_end_clock))
      else $error("back-end reset rose off an enable");
   a_cordic_abort: assert property ($past(be_reset) && $past(back_end_clock)
      |-> !cordic_busy && cordic_iter == 4'h0) else $error("converter not stopped");
   a_fifo_cleared: assert property ($past(be_reset) && $past(back_end_clock)
      |-> fifo_state == {SRA_FIFO_RD_INIT, SRA_FIFO_WR_INIT, 4'h0, 5'h08})
      else $error("fifo control not reset");
   a_snap_serial: assert property ($past(be_reset) && $past(back_end_clock)
      |-> snap_state == {3'h0, SRA_SNAP_INTERVAL, 6'h00}
      && serial_state == {SRA_SER_SHIFT, SRA_SER_WORDS, SRA_SER_SYNC, SRA_SER_DIV})
      else $error("snapshot or serial counters not reloaded");
   a_irq_quiet: assert property (be_reset |-> !host_interrupt && !fifo_state.data_avail)
      else $error("interrupt or data available during reset");
   a_load_fields: assert property (agc_load_strobe
      |-> agc_accumulator == {gain_seen, 5'h00}
      && agc_exponent == gain_seen[10:7]
      && agc_mantissa == {SRA_MANT_INT, gain_seen[6:0]}) else $error("gain fields wrong");
   a_load_on_enable: assert property (agc_load_strobe
      |-> $past(back_end_clock) && !$past(agc_load_strobe)) else $error("load strobe off rate");

   c_fe: cover property ($rose(fe_reset));
   c_be: cover property ($rose(be_reset));
   c_load: cover property (agc_load_strobe);
   c_irq: cover property ($rose(host_interrupt));
endmodule
bind sra_top sra_props sra_props_inst (.clk, .reset_n, .front_end_clock, .back_end_clock,
   .addr, .wdata, .wr,
   .fe_reset, .be_reset, .cordic_busy, .cordic_iter, .fifo_state, .snap_state, .serial_state,
   .agc_load_strobe, .agc_exponent, .agc_mantissa, .agc_accumulator, .host_interrupt);

// [tb/sra_host.sv]
/*
 * Host processor model: writes and reads control words on the register port.
 * Assumes read data stand only in the cycle after the read strobe.
 */
`timescale 1ns/1ps
module sra_host (
   // Clock.
   input  wire logic        clk,
   // Register port.
   output logic      [7:0]  addr,
   output logic      [31:0] wdata,
   output logic             wr,
   output logic             rd,
   input  wire logic [31:0] rdata
);
   initial begin
      addr = 8'hff;
      wdata = 32'h0000_0000;
      wr = 1'b0;
      rd = 1'b0;
   end

   // All 32 bits are driven valid; afterwards data flip so stale values never look held.
   task automatic write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      wdata <= ~d;
   endtask

   task automatic read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
endmodule

// [tb/tb.sv]
/*
 * Self-checking bench for sra_top.
 * Assumes enables every 2nd (front end) and 3rd (back end) clock cycle.
 */
`timescale 1ns/1ps
module tb;
   import sra_pkg::*;
   logic clk, reset_n, front_end_clock, back_end_clock, first_sync_input, second_sync_input;
   logic cordic_start, fifo_push, fifo_pop, snap_tick, serial_tick;
   logic [15:0] limiter_out;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, v;
   logic        wr, rd, fe_reset, be_reset, cordic_busy, agc_load_strobe, host_interrupt;
   logic [3:0]  cordic_iter, agc_exponent;
   logic [8:0]  agc_mantissa;
   logic [15:0] agc_accumulator;
   sra_fifo_t   fifo_state;
   sra_snap_t   snap_state;
   sra_serial_t serial_state;
   logic        fe_div = 1'b0;
   logic [1:0]  be_div = 2'h0;
   int          bad_count, n_tests, w;
   bit          sf, sb;

   sra_top sra_top_inst (.*);
   sra_host sra_host_inst (.clk, .addr, .wdata, .wr, .rd, .rdata);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      fe_div <= ~fe_div;
      be_div <= (be_div == 2'h2) ? 2'h0 : be_div + 2'h1;
      front_end_clock <= fe_div;
      back_end_clock <= (be_div == 2'h0);
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask

   task automatic test_done;
      $display("mismatches %0d of %0d checks", bad_count, n_tests);
      if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Watch both resets for a span after a request.
   task automatic watch(input int n);
      sf = 0;
      sb = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         sf |= fe_reset;
         sb |= be_reset;
      end
   endtask

   task automatic chk_idle;
      chk("fifo", {SRA_FIFO_RD_INIT, SRA_FIFO_WR_INIT, 4'h0, 5'h08}, fifo_state);
      chk("cordic", 32'h0, {cordic_busy, cordic_iter});
      chk("snap", {3'h0, SRA_SNAP_INTERVAL, 6'h00}, snap_state);
      chk("serial", {SRA_SER_SHIFT, SRA_SER_WORDS, SRA_SER_SYNC, SRA_SER_DIV}, serial_state);
      chk("irq", 32'h0, {fifo_state.data_avail, host_interrupt});
   endtask

   task automatic t_soft_reset;
      logic [31:0] nf;
      logic [31:0] nb;
      {fifo_push, cordic_start, snap_tick, serial_tick} <= 4'hf;
      repeat (12) @(posedge clk);
      {fifo_push, cordic_start, snap_tick, serial_tick} <= 4'h0;
      #1 chk("busy", 32'h3, {cordic_busy, fifo_state.data_avail});
      sra_host_inst.write(SRA_ADDR_SOFT_RESET, 32'h0);
      nf = 32'h0000_0000;
      nb = 32'h0000_0000;
      // Count high cycles of each reset, sampled just after each edge.
      repeat (60) begin
         @(posedge clk);
         #1;
         nf += fe_reset;
         nb += be_reset;
      end
      chk("fe width", SRA_RESET_PERIODS * 2, nf);
      chk("be width", SRA_RESET_PERIODS * 3, nb);
      chk_idle;
   endtask

   task automatic t_gain_load;
      sra_host_inst.write(SRA_ADDR_GAIN_LOAD, 32'hffff_abff);
      for (w = 0; w < 10 && agc_load_strobe !== 1'b1; w++) @(posedge clk) #1;
      chk("acc", 32'hABE0, agc_accumulator);
      chk("exp", 32'hA, agc_exponent);
      chk("mant", {SRA_MANT_INT, 7'h5f}, agc_mantissa);
      repeat (4) @(posedge clk);
      #1 chk("limiter", 32'h1234, agc_accumulator);
      sra_host_inst.read(SRA_ADDR_AGC_ACC, v);
      chk("acc read", 32'h1234, v);
      sra_host_inst.read(SRA_ADDR_GAIN_LOAD, v);
      chk("wo read", 32'h0, v);
      sra_host_inst.read(8'h55, v);
      chk("unmapped", 32'h0, v);
   endtask

   task automatic t_clear;
      for (int i = 0; i < 4; i++) begin
         sra_host_inst.write(SRA_ADDR_CONFIG, {16'h0, i[1], 15'h0});
         if (i[0]) sra_host_inst.write(SRA_ADDR_SOFT_RESET, 32'h0);
         else begin
            @(posedge clk) second_sync_input <= 1'b1;
            @(posedge clk) second_sync_input <= 1'b0;
         end
         sf = 0;
         repeat (7) @(posedge clk) #1 sf |= (agc_accumulator === 16'h0);
         chk("acc clear", {31'h0, !i[1]}, {31'h0, sf});
         repeat (40) @(posedge clk);
      end
   endtask

   task automatic t_sync1;
      for (int i = 0; i < 2; i++) begin
         sra_host_inst.write(SRA_ADDR_CONFIG, {9'h0, i[0], 22'h0});
         @(posedge clk) first_sync_input <= 1'b1;
         @(posedge clk) first_sync_input <= 1'b0;
         watch(40);
         chk("sync1 resets", {30'h0, 1'b1, i[0]}, {30'h0, sf, sb});
      end
   endtask

   task automatic t_irq;
      sra_host_inst.write(SRA_ADDR_IRQ_MASK, 32'h0);
      sra_host_inst.write(SRA_ADDR_IRQ_STATUS, 32'hf);
      sra_host_inst.write(SRA_ADDR_SOFT_RESET, 32'h0);
      watch(40);
      chk("masked", 32'h0, host_interrupt);
      sra_host_inst.read(SRA_ADDR_IRQ_STATUS, v);
      chk("status", 32'h6, v);
      sra_host_inst.write(SRA_ADDR_IRQ_MASK, 32'h6);
      @(posedge clk) #1 chk("unmasked", 32'h1, host_interrupt);
      sra_host_inst.write(SRA_ADDR_IRQ_STATUS, 32'h2);
      @(posedge clk) #1 chk("one left", 32'h1, host_interrupt);
      sra_host_inst.write(SRA_ADDR_SOFT_RESET, 32'h0);
      repeat (4) @(posedge clk);
      #1 chk("irq in reset", 32'h2, {be_reset, host_interrupt});
      watch(40);
      sra_host_inst.write(SRA_ADDR_IRQ_STATUS, 32'h6);
      @(posedge clk) #1 chk("cleared", 32'h0, host_interrupt);
   endtask

   initial begin
      reset_n = 1'b0;
      {first_sync_input, second_sync_input, cordic_start, fifo_push} = 4'h0;
      {fifo_pop, snap_tick, serial_tick} = 3'h0;
      limiter_out = 16'h1234;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk_idle;
      t_soft_reset;
      t_gain_load;
      t_clear;
      t_sync1;
      t_irq;
      test_done;
   end

   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      test_done;
   end
endmodule
